// File: design/aux_gpio_cfg.sv
`timescale 1ns/100ps
`default_nettype none
module aux_gpio_cfg (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      ce,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic [31:0]                    hrdata,
	input  wire logic                      mod_clk_tick,
	input  wire logic [1:0]                aux_pin_in,
	output aux_cfg_pkg::aux_drive_t        aux_drive,
	input  wire logic [6:0]                pwm_high_threshold,
	output logic [1:0]                     aux_pin_level,
	output logic                           section2_check_enable,
	output logic [15:0]                    section1_check_value,
	output logic [2:0]                     test_dac_level_select,
	output logic signed [6:0]              test_dac_multiple
);
	import aux_cfg_pkg::*;

	state_t      st;
	state_t      next_st;
	logic        take;
	logic        mapped;
	logic [7:0]  idx;
	logic [1:0]  rise;
	logic [1:0]  tick_end;
	logic [1:0]  fmt;
	logic [1:0]  tb_sel [2];

	// Word transfers only; size is not checked, every answer is OKAY
	assign take      = hsel && htrans[1] && hready;
	assign mapped    = haddr[31:10] == 22'h000000;
	assign idx       = mapped ? haddr[9:2] : IDX_NONE;
	// A low enable stretches any transfer so no access is lost
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign hrdata    = {16'h0000, st.rdata};

	assign section2_check_enable = st.crc_en;
	assign section1_check_value  = st.s1crc;
	assign test_dac_level_select = st.dac_sel;
	assign test_dac_multiple     = st.dac_mult;
	assign aux_pin_level         = st.lvl;

	// Pin drives only when set as output; level bit ignored otherwise
	assign aux_drive.oe[1]  = st.pin_cfg[PIN1_DIR];
	assign aux_drive.oe[0]  = st.pin_cfg[PIN0_DIR];
	assign aux_drive.out[1] = st.pin_cfg[PIN1_DIR]
	                        & st.pin_cfg[PIN1_LEVEL];
	assign aux_drive.out[0] = st.pin_cfg[PIN0_DIR]
	                        & st.pin_cfg[PIN0_LEVEL];

	assign fmt[1]    = st.pin_cfg[PIN1_FMT];
	assign fmt[0]    = st.pin_cfg[PIN0_FMT];
	assign tb_sel[1] = st.pin_cfg[PIN1_TB_LSB +: 2];
	assign tb_sel[0] = st.pin_cfg[PIN0_TB_LSB +: 2];

	always_comb begin
		next_st = st;
		rise = 2'b00;
		tick_end = 2'b00;
		if (st.pend && st.pwr) begin
			case (st.pidx)
				IDX_S2_CFG: begin
					next_st.crc_en  = hwdata[S2_EN_BIT];
					next_st.dac_sel = hwdata[2:0];
				end
				// Spare bits are kept only so the section check covers them
				IDX_PIN_CFG: next_st.pin_cfg = hwdata[14:0];
				IDX_S1_CRC:  next_st.s1crc = hwdata[15:0];
				default: ;
			endcase
		end
		next_st.dac_mult = dac_mult(next_st.dac_sel);
		next_st.pend = take;
		next_st.pwr  = hwrite;
		next_st.pidx = idx;
		for (int i = 0; i < 2; i++) begin
			rise[i] = aux_pin_in[i] & ~st.dec[i].prev;
			tick_end[i] = mod_clk_tick
			            && st.dec[i].tb_cnt == tb_last(tb_sel[i]);
			next_st.dec[i].prev = aux_pin_in[i];
			if (rise[i]) begin
				// A rising edge closes one high-plus-low period
				next_st.dec[i].level = st.dec[i].hi
				                     >= pwm_high_threshold;
				next_st.dec[i].hi = 7'h00;
				next_st.dec[i].lo = 7'h00;
				next_st.dec[i].tb_cnt = 10'h000;
			end else if (tick_end[i]) begin
				next_st.dec[i].tb_cnt = 10'h000;
				// Counts saturate: a stuck input holds its count at COUNT_MAX, it does not wrap
				if (aux_pin_in[i] && st.dec[i].hi != COUNT_MAX)
					next_st.dec[i].hi = st.dec[i].hi + 7'h01;
				else if (!aux_pin_in[i] && st.dec[i].lo != COUNT_MAX)
					next_st.dec[i].lo = st.dec[i].lo + 7'h01;
			end else if (st.dec[i].tb_cnt > tb_last(tb_sel[i])) begin
				// A shorter time base picked once the count is past its last count restarts the count
				next_st.dec[i].tb_cnt = 10'h000;
			end else if (mod_clk_tick) begin
				next_st.dec[i].tb_cnt = st.dec[i].tb_cnt + 10'h001;
			end
			next_st.lvl[i] = fmt[i] ? next_st.dec[i].level
			                        : aux_pin_in[i];
		end
		// Read data comes from the updated copy, so a read right
		// behind a write to the same register sees the new value
		if (take && !hwrite)
			next_st.rdata = reg_read(idx, next_st);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.crc_en <= S2_CFG_RESET[S2_EN_BIT];
			st.dac_sel <= S2_CFG_RESET[2:0];
			st.dac_mult <= DAC_MULT_RESET;
			st.pin_cfg <= PIN_CFG_RESET[14:0];
			st.s1crc <= S1_CRC_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	s2_enable_write_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pend && st.pwr && st.pidx == IDX_S2_CFG)
		|=> section2_check_enable == $past(hwdata[15]))
		else $error("check enable did not follow write");

	s2_zero_read_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && take && !hwrite && idx == IDX_S2_CFG)
		|=> hrdata[14:3] == 12'h000 && hrdata[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");

	s1_value_store_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pend && st.pwr && st.pidx == IDX_S1_CRC)
		|=> section1_check_value == $past(hwdata[15:0]))
		else $error("section one value not stored");

	spare_store_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pend && st.pwr && st.pidx == IDX_PIN_CFG)
		|=> st.pin_cfg[14:12] == $past(hwdata[14:12])
		&& st.pin_cfg[3:2] == $past(hwdata[3:2]))
		else $error("spare bits not stored");

	pin1_drive_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pend && st.pwr && st.pidx == IDX_PIN_CFG)
		|=> aux_drive.oe[1] == $past(hwdata[9])
		&& aux_drive.out[1] == ($past(hwdata[9]) && $past(hwdata[1])))
		else $error("pin 1 drive wrong after write");

	pin0_drive_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pend && st.pwr && st.pidx == IDX_PIN_CFG)
		|=> aux_drive.oe[0] == $past(hwdata[8])
		&& aux_drive.out[0] == ($past(hwdata[8]) && $past(hwdata[0])))
		else $error("pin 0 drive wrong after write");

	dac_level_map_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(st.dac_sel == 3'h5 |-> test_dac_multiple == 7'sh24)
		and (st.dac_sel == 3'h7 |-> test_dac_multiple == -7'sh09))
		else $error("test DAC multiple wrong");

	tb0_bound_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && mod_clk_tick && !rise[0] && tick_end[0])
		|=> st.dec[0].tb_cnt == 10'h000)
		else $error("pin 0 time base did not wrap");

	tb1_bound_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.dec[1].tb_cnt > tb_last(tb_sel[1]))
		|=> st.dec[1].tb_cnt == 10'h000)
		else $error("pin 1 time base overran");

	high_count_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && tick_end[0] && !rise[0] && aux_pin_in[0]
		&& st.dec[0].hi != COUNT_MAX)
		|=> st.dec[0].hi == $past(st.dec[0].hi) + 7'h01)
		else $error("high count did not advance");

	pwm_decode_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && rise[0])
		|=> st.dec[0].level
		== ($past(st.dec[0].hi) >= $past(pwm_high_threshold))
		&& st.dec[0].hi == 7'h00 && st.dec[0].lo == 7'h00)
		else $error("decoded level wrong at period end");

	pin0_static_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && !fmt[0] && !(st.pend && st.pwr))
		|=> aux_pin_level[0] == $past(aux_pin_in[0]))
		else $error("pin 0 static level not followed");

	pin1_pwm_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && fmt[1] && !(st.pend && st.pwr))
		|=> aux_pin_level[1] == st.dec[1].level)
		else $error("pin 1 decoded level not shown");

	pin0_dir_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!st.pin_cfg[PIN0_DIR] |-> !aux_drive.oe[0] && !aux_drive.out[0])
		else $error("pin 0 driven while input");

	s1_read_back_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && take && !hwrite && idx == IDX_S1_CRC
		&& !(st.pend && st.pwr))
		|=> hrdata[15:0] == $past(section1_check_value))
		else $error("section one value read wrong");

	s2_fields_read_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && take && !hwrite && idx == IDX_S2_CFG
		&& !(st.pend && st.pwr))
		|=> hrdata[2:0] == $past(test_dac_level_select)
		&& hrdata[15] == $past(section2_check_enable))
		else $error("section two fields read wrong");

	dac_select_write_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pend && st.pwr && st.pidx == IDX_S2_CFG)
		|=> test_dac_level_select == $past(hwdata[2:0]))
		else $error("test DAC select did not follow write");

	dac_low_map_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(st.dac_sel == 3'h0 |-> test_dac_multiple == 7'sh01)
		and (st.dac_sel == 3'h1 |-> test_dac_multiple == 7'sh02)
		and (st.dac_sel == 3'h2 |-> test_dac_multiple == 7'sh04)
		and (st.dac_sel == 3'h4 |-> test_dac_multiple == 7'sh12)
		and (st.dac_sel == 3'h6 |-> test_dac_multiple == -7'sh04))
		else $error("test DAC multiple wrong for low codes");

	pin_cfg_read_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && take && !hwrite && idx == IDX_PIN_CFG
		&& !(st.pend && st.pwr))
		|=> hrdata[15:0] == {1'b1, $past(st.pin_cfg)})
		else $error("pin configuration read wrong");

	pin1_dir_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!st.pin_cfg[PIN1_DIR] |-> !aux_drive.oe[1] && !aux_drive.out[1])
		else $error("pin 1 driven while input");

	pin1_level_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		st.pin_cfg[PIN1_DIR] |-> aux_drive.out[1] == st.pin_cfg[PIN1_LEVEL])
		else $error("pin 1 output level wrong");

	pin1_out_static_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pin_cfg[PIN1_DIR] && !(st.pend && st.pwr))
		|=> $stable(aux_drive.out[1]))
		else $error("pin 1 output not static");

	pin0_out_static_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && st.pin_cfg[PIN0_DIR] && !(st.pend && st.pwr))
		|=> $stable(aux_drive.out[0]))
		else $error("pin 0 output not static");

	pin1_static_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && !fmt[1] && !(st.pend && st.pwr))
		|=> aux_pin_level[1] == $past(aux_pin_in[1]))
		else $error("pin 1 static level not followed");

	pin0_pwm_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && fmt[0] && !(st.pend && st.pwr))
		|=> aux_pin_level[0] == st.dec[0].level)
		else $error("pin 0 decoded level not shown");

	tb1_wrap_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && mod_clk_tick && !rise[1] && tick_end[1])
		|=> st.dec[1].tb_cnt == 10'h000)
		else $error("pin 1 time base did not wrap");

	low_count_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && tick_end[0] && !rise[0] && !aux_pin_in[0]
		&& st.dec[0].lo != COUNT_MAX)
		|=> st.dec[0].lo == $past(st.dec[0].lo) + 7'h01)
		else $error("low count did not advance");

	count_hold_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && !rise[0] && !tick_end[0])
		|=> $stable(st.dec[0].hi) && $stable(st.dec[0].lo))
		else $error("counts moved between time base ends");

	pwm1_decode_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && rise[1])
		|=> st.dec[1].level
		== ($past(st.dec[1].hi) >= $past(pwm_high_threshold))
		&& st.dec[1].hi == 7'h00 && st.dec[1].lo == 7'h00)
		else $error("pin 1 decoded level wrong at period end");

	crc_en_hold_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && !(st.pend && st.pwr && st.pidx == IDX_S2_CFG))
		|=> $stable(section2_check_enable))
		else $error("check enable changed without write");

	level_hold_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ce && !rise[0])
		|=> $stable(st.dec[0].level))
		else $error("decoded level changed inside period");

endmodule // aux_gpio_cfg
`default_nettype wire

// File: include/aux_cfg_pkg.sv
package aux_cfg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_S1_CRC   = 8'h7e;
	localparam logic [7:0]  IDX_STATUS   = 8'h7f;
	localparam logic [7:0]  IDX_S2_CFG   = 8'h80;
	localparam logic [7:0]  IDX_PIN_CFG  = 8'h81;
	localparam logic [7:0]  IDX_NONE     = 8'h00;

	localparam logic [15:0] S2_CFG_RESET  = 16'h0000;
	localparam logic [15:0] PIN_CFG_RESET = 16'h8000;
	localparam logic [15:0] S1_CRC_RESET  = 16'h0000;
	localparam logic signed [6:0] DAC_MULT_RESET = 7'sh01;

	localparam int S2_EN_BIT   = 15;
	localparam int PIN_FIXED   = 15;
	localparam int PIN1_FMT    = 11;
	localparam int PIN0_FMT    = 10;
	localparam int PIN1_DIR    = 9;
	localparam int PIN0_DIR    = 8;
	localparam int PIN1_TB_LSB = 6;
	localparam int PIN0_TB_LSB = 4;
	localparam int PIN1_LEVEL  = 1;
	localparam int PIN0_LEVEL  = 0;

	localparam logic [6:0]  COUNT_MAX   = 7'h7f;

	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
	} aux_drive_t;

	typedef struct packed {
		logic [9:0] tb_cnt;
		logic [6:0] hi;
		logic [6:0] lo;
		logic       prev;
		logic       level;
	} pwm_dec_t;

	typedef struct packed {
		logic              pend;
		logic              pwr;
		logic [7:0]        pidx;
		logic [15:0]       rdata;
		logic              crc_en;
		logic [2:0]        dac_sel;
		logic signed [6:0] dac_mult;
		logic [14:0]       pin_cfg;
		logic [15:0]       s1crc;
		logic [1:0]        lvl;
		pwm_dec_t [1:0]    dec;
	} state_t;

	// Last count of a time base: 16, 64, 256 or 1024 modulator periods
	function automatic logic [9:0] tb_last(input logic [1:0] sel);
		case (sel)
			2'h0: tb_last = 10'h00f;
			2'h1: tb_last = 10'h03f;
			2'h2: tb_last = 10'h0ff;
			default: tb_last = 10'h3ff;
		endcase
	endfunction

	function automatic logic signed [6:0] dac_mult(input logic [2:0] sel);
		case (sel)
			3'h0: dac_mult = 7'sh01;
			3'h1: dac_mult = 7'sh02;
			3'h2: dac_mult = 7'sh04;
			3'h3: dac_mult = 7'sh09;
			3'h4: dac_mult = 7'sh12;
			3'h5: dac_mult = 7'sh24;
			3'h6: dac_mult = -7'sh04;
			default: dac_mult = -7'sh09;
		endcase
	endfunction

	function automatic logic [15:0] reg_read(input logic [7:0] idx,
	                                         input state_t s);
		case (idx)
			IDX_S2_CFG:  reg_read = {s.crc_en, 12'h000, s.dac_sel};
			IDX_PIN_CFG: reg_read = {1'b1, s.pin_cfg};
			IDX_S1_CRC:  reg_read = s.s1crc;
			IDX_STATUS:  reg_read = {14'h0000, s.lvl};
			default:     reg_read = 16'h0000;
		endcase
	endfunction

endpackage

// File: test/aux_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module aux_pin_model (
	input  wire logic                    hclk,
	input  wire aux_cfg_pkg::aux_drive_t aux_drive,
	input  wire logic [1:0]              ext_level,
	input  wire logic                    pwm_on,
	input  wire logic [7:0]              hi_cyc,
	input  wire logic [7:0]              lo_cyc,
	output logic [1:0]                   aux_pin_in
);
	import aux_cfg_pkg::*;
	logic [8:0] cnt = 9'h000;
	logic       wave;
	logic [9:0] span;
	assign span = 10'(hi_cyc) + 10'(lo_cyc) - 10'h001;
	always @(posedge hclk) begin
		cnt <= (!pwm_on || 10'(cnt) == span) ? 9'h000 : cnt + 9'h001;
	end
	assign wave = pwm_on && (cnt < 9'(hi_cyc));
	// A driven pin reads back its own level; otherwise the far side drives it
	assign aux_pin_in = (aux_drive.oe & aux_drive.out)
		| (~aux_drive.oe & (pwm_on ? {2{wave}} : ext_level));
endmodule // aux_pin_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import aux_cfg_pkg::*;
	logic              hclk, hresetn, hsel, hwrite, pwm_on, hreadyout, hresp;
	logic [1:0]        htrans, ext_level, pin_in, pin_level;
	logic [31:0]       haddr, hwdata, hrdata, rd, v;
	logic [6:0]        thr;
	logic [7:0]        hi_cyc, lo_cyc;
	logic              s2_en;
	logic              ce = 1'b1;
	logic              stall = 1'b0;
	int                regs[int];
	logic [15:0]       s1_val;
	logic [2:0]        dac_sel;
	logic signed [6:0] dac_mult;
	aux_drive_t        drive;
	int seed = 70, miscompares = 0, n_checks = 0, cycles = 0;
	int m_pin, hi;
	int dac_tab[8] = '{1, 2, 4, 9, 18, 36, -4, -9};
	aux_gpio_cfg u_aux_gpio_cfg (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mod_clk_tick(1'b1), .aux_pin_in(pin_in), .aux_drive(drive),
		.pwm_high_threshold(thr), .aux_pin_level(pin_level),
		.section2_check_enable(s2_en), .section1_check_value(s1_val),
		.test_dac_level_select(dac_sel), .test_dac_multiple(dac_mult));
	aux_pin_model u_aux_pin_model (.hclk(hclk), .aux_drive(drive),
		.ext_level(ext_level), .pwm_on(pwm_on), .hi_cyc(hi_cyc),
		.lo_cyc(lo_cyc), .aux_pin_in(pin_in));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		// Random enable drops stretch bus transfers with wait states
		ce <= !stall || ($random(seed) & 3) != 0;
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict;
		end
	end
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task chk_port(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: port %h want %h", $time, got, exp);
		end
	endtask
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0000_0000;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk_reg({31'h0, hresp}, 32'h0000_0000);
		if (wr) begin
			case (a)
				32'h1f8: regs[a] = d & 32'h0000_ffff;
				32'h200: regs[a] = d & 32'h0000_8007;
				32'h204: regs[a] = 32'(PIN_CFG_RESET) | (d & 32'h0000_7fff);
				default: ;
			endcase
		end
	endtask
	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		chk_reg(rd, exp);
		if (regs.exists(a)) chk_reg(rd, 32'(regs[a]));
	endtask
	initial begin
		{hresetn, hsel, hwrite, pwm_on} = 4'h0;
		{htrans, ext_level} = 4'h0;
		{haddr, hwdata} = 64'h0;
		{thr, hi_cyc, lo_cyc} = 23'h0;
		regs[32'h1f8] = 32'(S1_CRC_RESET);
		regs[32'h200] = 32'(S2_CFG_RESET);
		regs[32'h204] = 32'(PIN_CFG_RESET);
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(32'h1f8, 32'h0000_0000);
		rd_chk(32'h200, 32'h0000_0000);
		rd_chk(32'h204, 32'h0000_8000);
		chk_port({s2_en, 12'h000, dac_sel}, 16'h0000);
		chk_port({12'h000, drive}, 16'h0000);
		$display("test reset done");
		stall <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			v[2:0] = 3'(i);
			ahb(1'b1, 32'h200, v);
			ahb(1'b1, 32'h1f8, ~v);
			rd_chk(32'h200, v & 32'h0000_8007);
			rd_chk(32'h1f8, {16'h0000, ~v[15:0]});
			chk_port({s2_en, 12'h000, dac_sel}, v[15:0] & 16'h8007);
			chk_port(16'(dac_mult), 16'(dac_tab[i]));
			chk_port(s1_val, ~v[15:0]);
		end
		$display("test section cfg done");
		for (int i = 0; i < 8; i++) begin
			v = $random(seed) & 32'h0000_7fff;
			ahb(1'b1, 32'h204, v);
			m_pin = {1'b1, v[14:0]};
			ahb(1'b1, 32'h208, ~v);
			rd_chk(32'h208, 32'h0000_0000);
			rd_chk(32'h204, m_pin);
			chk_port({12'h000, drive}, {12'h000, v[1:0] & v[9:8], v[9:8]});
		end
		stall <= 1'b0;
		$display("test pin cfg done");
		ahb(1'b1, 32'h204, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			ext_level <= 2'($random(seed));
			repeat (3) @(posedge hclk);
			@(negedge hclk);
			chk_port({14'h0, pin_level}, {14'h0, ext_level});
			rd_chk(32'h1fc, {30'h0, ext_level});
		end
		$display("test static input done");
		// Pin 0 counts in 16-tick units, pin 1 in 64-tick units
		ahb(1'b1, 32'h204, 32'h0000_0c40);
		thr <= 7'h04;
		for (int i = 0; i < 2; i++) begin
			hi = i ? 32 : 96;
			hi_cyc <= 8'(hi);
			lo_cyc <= 8'(128 - hi);
			pwm_on <= 1'b1;
			repeat (600) @(posedge hclk);
			@(negedge hclk);
			chk_port({14'h0, pin_level}, {14'h0, hi / 64 >= 4, hi / 16 >= 4});
		end
		$display("test pwm decode done");
		give_verdict;
	end
endmodule // tb_top
`default_nettype wire
